/* File: rtl/ext_state_pkg.sv */
// Constants, types and carriers for the extended-state restore and save control block.
// What this block does
// R1 - Requested mask is feature enable ANDed with the 64-bit instruction mask.
// R2 - Fault order: disabled save gives undefined-op, task switched device-unavailable, misalignment protection.
// R3 - After checks, header layout bit 63 selects standard or compacted restore.
// R4 - Standard form faults on present bits outside feature enable or nonzero bytes 23:8.
// R5 - Requested components with present bit 0 are initialised, with present bit 1 loaded.
// R6 - Standard form loads SIMD control/status when requested bit 1 or 2 is set.
// R7 - Either form faults instead of loading an illegal SIMD control/status value.
// R8 - Components 0 and 1 use legacy region, 2 to 62 standard extended layout.
// R9 - Compacted form faults on bad layout bits, stray present bits, nonzero bytes 63:16.
// R10 - Compacted form sets SIMD control/status to 1F80H when requested bit 1 is set and present bit 1 is 0.
// R11 - Compacted form initialises requested, not-present components even if layout bit is 0.
// R12 - Compacted form loads SIMD control/status only if requested and present bit 1 set.
// R13 - Compacted form locates extended components by the compacted layout.
// R14 - Restore leaves unrequested in-use bits, sets present ones, may clear others.
// R15 - Restore sets modified bits of unrequested components, requested ones may be cleared.
// R16 - Restore records privilege, non-root flag, area address and layout; standard stores zero.
// R17 - Save reads present bitmap, writes back in-use bits where requested.
// R18 - Save may write present bit 1 as 0 whatever SIMD control/status holds.
// R19 - Save changes no header field except the present bitmap.
// R20 - Save stores requested components in legacy and standard extended layout.
// R21 - Software should keep header bytes 63:16 zero, and 15:8 without compaction.
// R22 - Without compaction support the standard form always runs, whatever layout bit 63 holds.
// R23 - x87 initial state: control 037FH, status 0000H, tag FFFFH, rest zero.
// R24 - Save does not write components whose in-use bit is clear.
// R25 - All fault and header checks finish before any state or bitmap changes.
package ext_state_pkg;

	localparam logic [63:0] HDR_OFS     = 64'h0000_0000_0000_0200;
	localparam logic [63:0] SIMD_OFS    = 64'h0000_0000_0000_0018;
	localparam int          LAYOUT_BIT  = 63;
	localparam int          TS_BIT      = 3;
	localparam int          OSE_BIT     = 0;
	localparam logic [31:0] SIMD_INIT   = 32'h0000_1f80;
	localparam logic [15:0] X87_CW_INIT = 16'h037f;
	localparam logic [15:0] X87_SW_INIT = 16'h0000;
	localparam logic [15:0] X87_TW_INIT = 16'hffff;
	localparam logic [63:0] INUSE_RST   = 64'h0000_0000_0000_0000;
	localparam logic [63:0] MOD_RST     = 64'hffff_ffff_ffff_ffff;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_FEAT_LO = 8'h04;
	localparam logic [7:0] OFS_FEAT_HI = 8'h08;
	localparam logic [7:0] OFS_STATUS  = 8'h0c;
	localparam logic [7:0] OFS_USE_LO  = 8'h10;
	localparam logic [7:0] OFS_USE_HI  = 8'h14;
	localparam logic [7:0] OFS_MOD_LO  = 8'h18;
	localparam logic [7:0] OFS_MOD_HI  = 8'h1c;
	localparam logic [7:0] OFS_SIMD    = 8'h20;

	typedef enum logic [1:0] {
		F_NONE    = 2'h0,
		F_UNDEF   = 2'h1,
		F_UNAVAIL = 2'h2,
		F_PROT    = 2'h3
	} fault_type;

	typedef enum logic [6:0] {
		S_IDLE   = 7'h01,
		S_HDR    = 7'h02,
		S_SIMD   = 7'h04,
		S_APPLY  = 7'h08,
		S_SAVERD = 7'h10,
		S_SAVEWR = 7'h20,
		S_DONE   = 7'h40
	} ctl_state_type;

	typedef struct packed {
		logic        valid;
		logic        isRestore;
		logic [63:0] mask;
		logic [63:0] area;
		logic [1:0]  priv;
		logic        vmx;
	} instr_req_type;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [63:0] addr;
		logic [63:0] wdata;
	} mem_req_type;

	typedef struct packed {
		logic        ack;
		logic [63:0] rdata;
	} mem_rsp_type;

	typedef struct packed {
		logic        done;
		fault_type   fault;
		logic        compacted;
		logic [63:0] loadMask;
		logic [63:0] initMask;
		logic [63:0] storeMask;
		logic        simdLoad;
		logic        simdInit;
	} result_type;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_type;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} apb_rsp_type;

endpackage : ext_state_pkg

/* File: rtl/ext_state_restore_save_ctl.sv */
// Restore and optimised-save control for the extended processor state.
`timescale 1ns/1ps
module ext_state_restore_save_ctl #(
	parameter bit          COMPACT_SUPPORT = 1'b1,
	parameter logic [31:0] SIMD_LEGAL_MASK = 32'h0000_ffff
) (
	input  wire logic                       clock,
	input  wire logic                       rst_b,
	input  wire ext_state_pkg::apb_req_type apbReq,
	output      ext_state_pkg::apb_rsp_type apbRsp,
	input  wire ext_state_pkg::instr_req_type instrReq,
	output      logic                       instrReady,
	output      ext_state_pkg::mem_req_type memReq,
	input  wire ext_state_pkg::mem_rsp_type memRsp,
	output      ext_state_pkg::result_type  result,
	output      logic [31:0]                simdCtlStatus,
	output      logic [47:0]                x87InitWords
);

	generate
		if (SIMD_LEGAL_MASK == 32'h0000_0000) begin : g_bad_mask
			$error("SIMD_LEGAL_MASK must allow at least one bit");
		end
	endgenerate

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic                         ose;
		logic                         ts;
		logic [63:0]                  feat;
		logic [63:0]                  inUse;
		logic [63:0]                  modified;
		ext_state_pkg::ctl_state_type state;
		logic                         isRestore;
		logic [63:0]                  mask;
		logic [63:0]                  area;
		logic [1:0]                   priv;
		logic                         vmx;
		logic [2:0]                   word;
		logic [63:0]                  present;
		logic [63:0]                  layout;
		logic [63:0]                  hdr2;
		logic                         restNz;
		logic [31:0]                  simdMem;
		logic [31:0]                  simd;
		logic [47:0]                  x87;
		logic [1:0]                   recPriv;
		logic                         recVmx;
		logic [63:0]                  recArea;
		logic [63:0]                  recLayout;
		logic                         memWe;
		logic [63:0]                  memAddr;
		logic [63:0]                  memWdata;
		ext_state_pkg::result_type    res;
		logic [31:0]                  prdata;
	} ctl_reg_type;

	ctl_reg_type st_q;
	ctl_reg_type st_d;

	logic        taken;
	logic        memBusy;
	logic        compactForm;
	logic        hdrFault;
	logic        simdLoadW;
	logic        simdInitW;
	logic        modMatch;
	logic [63:0] newPresent;

	assign instrReady = (st_q.state == ext_state_pkg::S_IDLE);
	assign taken      = instrReq.valid && instrReady;
	assign memBusy    = (st_q.state == ext_state_pkg::S_HDR) ||
	                    (st_q.state == ext_state_pkg::S_SIMD) ||
	                    (st_q.state == ext_state_pkg::S_SAVERD) ||
	                    (st_q.state == ext_state_pkg::S_SAVEWR);

	// One assignment per carrier keeps a single driver on each packed output.
	assign memReq = '{req: memBusy, we: st_q.memWe, addr: st_q.memAddr, wdata: st_q.memWdata};
	assign result        = st_q.res;
	assign simdCtlStatus = st_q.simd;
	assign x87InitWords  = st_q.x87;

	assign apbRsp = '{pready:  1'b1,
	                  pslverr: apbReq.psel && apbReq.penable &&
	                           (apbReq.paddr > ext_state_pkg::OFS_SIMD ||
	                            apbReq.paddr[1:0] != 2'h0),
	                  prdata:  st_q.prdata};

	// ------------------------------------------------------------
	// Restore decisions
	// ------------------------------------------------------------
	always_comb begin
		compactForm = COMPACT_SUPPORT && st_q.layout[ext_state_pkg::LAYOUT_BIT]; // R3 R22
		if (compactForm) begin
			hdrFault = ((st_q.layout[62:0] & ~st_q.feat[62:0]) != 63'h0) ||  // R9
			           ((st_q.present & ~st_q.layout) != 64'h0) ||
			           (st_q.hdr2 != 64'h0) || st_q.restNz;
			simdLoadW = st_q.mask[1] && st_q.present[1];                     // R12
			simdInitW = st_q.mask[1] && !st_q.present[1];                    // R10
		end else begin
			// Bytes 23:8 cover the layout word and the next header word.
			hdrFault = ((st_q.present & ~st_q.feat) != 64'h0) ||            // R4
			           (st_q.layout != 64'h0) || (st_q.hdr2 != 64'h0);
			simdLoadW = st_q.mask[1] || st_q.mask[2];                        // R6
			simdInitW = 1'b0;
		end
		if (simdLoadW && ((st_q.simdMem & ~SIMD_LEGAL_MASK) != 32'h0)) begin
			hdrFault = 1'b1;                                                 // R7
		end
	end

	// The modified optimisation only applies after a standard restore of this area.
	assign modMatch = (st_q.recPriv == st_q.priv) && (st_q.recVmx == st_q.vmx) &&
	                  (st_q.recArea == st_q.area) && (st_q.recLayout == 64'h0);
	assign newPresent = (memRsp.rdata & ~st_q.mask) | (st_q.inUse & st_q.mask); // R17 R18

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.res.done = 1'b0;
		if (apbReq.psel && !apbReq.penable) begin
			case (apbReq.paddr)
				ext_state_pkg::OFS_CTRL:    st_d.prdata = {28'h0, st_q.ts, 2'h0, st_q.ose};
				ext_state_pkg::OFS_FEAT_LO: st_d.prdata = st_q.feat[31:0];
				ext_state_pkg::OFS_FEAT_HI: st_d.prdata = st_q.feat[63:32];
				ext_state_pkg::OFS_STATUS:  st_d.prdata = {22'h0, st_q.res.compacted,
				                                          !instrReady, 6'h0, st_q.res.fault};
				ext_state_pkg::OFS_USE_LO:  st_d.prdata = st_q.inUse[31:0];
				ext_state_pkg::OFS_USE_HI:  st_d.prdata = st_q.inUse[63:32];
				ext_state_pkg::OFS_MOD_LO:  st_d.prdata = st_q.modified[31:0];
				ext_state_pkg::OFS_MOD_HI:  st_d.prdata = st_q.modified[63:32];
				ext_state_pkg::OFS_SIMD:    st_d.prdata = st_q.simd;
				default:                    st_d.prdata = 32'h0;
			endcase
		end
		if (apbReq.psel && apbReq.penable && apbReq.pwrite) begin
			case (apbReq.paddr)
				ext_state_pkg::OFS_CTRL: begin
					st_d.ose = apbReq.pwdata[ext_state_pkg::OSE_BIT];
					st_d.ts  = apbReq.pwdata[ext_state_pkg::TS_BIT];
				end
				ext_state_pkg::OFS_FEAT_LO: st_d.feat[31:0]  = apbReq.pwdata;
				ext_state_pkg::OFS_FEAT_HI: st_d.feat[63:32] = apbReq.pwdata;
				default: ;
			endcase
		end
		case (st_q.state)
			ext_state_pkg::S_IDLE: begin
				if (taken) begin
					st_d.isRestore = instrReq.isRestore;
					st_d.mask      = st_q.feat & instrReq.mask;           // R1
					st_d.area      = instrReq.area;
					st_d.priv      = instrReq.priv;
					st_d.vmx       = instrReq.vmx;
					st_d.word      = 3'h0;
					st_d.restNz    = 1'b0;
					st_d.memWe     = 1'b0;
					st_d.memAddr   = instrReq.area + ext_state_pkg::HDR_OFS;
					st_d.res.loadMask  = 64'h0;
					st_d.res.initMask  = 64'h0;
					st_d.res.storeMask = 64'h0;
					st_d.res.simdLoad  = 1'b0;
					st_d.res.simdInit  = 1'b0;
					st_d.res.compacted = 1'b0;
					st_d.res.fault     = ext_state_pkg::F_NONE;
					if (!st_q.ose) begin
						st_d.res.fault = ext_state_pkg::F_UNDEF;              // R2
						st_d.state     = ext_state_pkg::S_DONE;
					end else if (st_q.ts) begin
						st_d.res.fault = ext_state_pkg::F_UNAVAIL;            // R2
						st_d.state     = ext_state_pkg::S_DONE;
					end else if (instrReq.area[5:0] != 6'h0) begin
						st_d.res.fault = ext_state_pkg::F_PROT;               // R2
						st_d.state     = ext_state_pkg::S_DONE;
					end else if (instrReq.isRestore) begin
						st_d.state = ext_state_pkg::S_HDR;
					end else begin
						st_d.state = ext_state_pkg::S_SAVERD;
					end
				end
			end
			ext_state_pkg::S_HDR: begin
				if (memRsp.ack) begin
					case (st_q.word)
						3'h0:    st_d.present = memRsp.rdata;
						3'h1:    st_d.layout  = memRsp.rdata;
						3'h2:    st_d.hdr2    = memRsp.rdata;
						default: st_d.restNz  = st_q.restNz || (memRsp.rdata != 64'h0);
					endcase
					st_d.word    = st_q.word + 3'h1;
					st_d.memAddr = st_q.memAddr + 64'h8;
					if (st_q.word == 3'h7) begin
						st_d.memAddr = st_q.area + ext_state_pkg::SIMD_OFS;
						st_d.state   = ext_state_pkg::S_SIMD;
					end
				end
			end
			ext_state_pkg::S_SIMD: begin
				if (memRsp.ack) begin
					st_d.simdMem = memRsp.rdata[31:0];
					st_d.state   = ext_state_pkg::S_APPLY;
				end
			end
			ext_state_pkg::S_APPLY: begin
				st_d.state = ext_state_pkg::S_DONE;
				if (hdrFault) begin
					st_d.res.fault = ext_state_pkg::F_PROT;                   // R25
				end else begin
					st_d.res.compacted = compactForm;                         // R8 R13
					st_d.res.loadMask  = st_q.mask & st_q.present;            // R5
					st_d.res.initMask  = st_q.mask & ~st_q.present;           // R5 R11
					st_d.res.simdLoad  = simdLoadW;
					st_d.res.simdInit  = simdInitW;
					if (simdLoadW) begin
						st_d.simd = st_q.simdMem;
					end else if (simdInitW) begin
						st_d.simd = ext_state_pkg::SIMD_INIT;
					end
					if (st_q.mask[0] && !st_q.present[0]) begin
						st_d.x87 = {ext_state_pkg::X87_CW_INIT, ext_state_pkg::X87_SW_INIT,
						            ext_state_pkg::X87_TW_INIT};                // R23
					end
					st_d.inUse     = (st_q.inUse & ~st_q.mask) | (st_q.mask & st_q.present); // R14
					st_d.modified  = ~st_q.mask;                              // R15
					st_d.recPriv   = st_q.priv;                               // R16
					st_d.recVmx    = st_q.vmx;
					st_d.recArea   = st_q.area;
					st_d.recLayout = compactForm ? st_q.layout : 64'h0;
				end
			end
			ext_state_pkg::S_SAVERD: begin
				if (memRsp.ack) begin
					st_d.memWe    = 1'b1;
					st_d.memWdata = newPresent;                               // R17 R19
					st_d.state    = ext_state_pkg::S_SAVEWR;
				end
			end
			ext_state_pkg::S_SAVEWR: begin
				if (memRsp.ack) begin
					st_d.memWe = 1'b0;
					st_d.state = ext_state_pkg::S_DONE;
					st_d.res.storeMask = st_q.mask & st_q.inUse &
					                     (modMatch ? st_q.modified : 64'hffff_ffff_ffff_ffff); // R20 R24
					st_d.res.simdLoad  = st_q.mask[1] || st_q.mask[2];
				end
			end
			ext_state_pkg::S_DONE: begin
				st_d.res.done = 1'b1;
				st_d.state    = ext_state_pkg::S_IDLE;
			end
			default: st_d.state = ext_state_pkg::S_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			st_q          <= '0;
			st_q.state    <= ext_state_pkg::S_IDLE;
			st_q.inUse    <= ext_state_pkg::INUSE_RST;
			st_q.modified <= ext_state_pkg::MOD_RST;
			st_q.simd     <= ext_state_pkg::SIMD_INIT;
			st_q.x87      <= {ext_state_pkg::X87_CW_INIT, ext_state_pkg::X87_SW_INIT,
			                  ext_state_pkg::X87_TW_INIT};
			st_q.res.fault <= ext_state_pkg::F_NONE;
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	a_undef_fault: assert property (taken && !st_q.ose |=> ##1 st_q.res.done && // R2
		st_q.res.fault == ext_state_pkg::F_UNDEF) else $error("undefined-op fault missed");
	a_align_fault: assert property (taken && st_q.ose && !st_q.ts && instrReq.area[5:0] != 6'h0 // R2
		|=> ##1 st_q.res.fault == ext_state_pkg::F_PROT) else $error("alignment fault missed");
	a_mask_form: assert property (taken |=> st_q.mask == ($past(st_q.feat) & $past(instrReq.mask))) // R1
		else $error("requested mask wrong");
	// Checked in the cycle after the apply step, where a faulty update would first show.
	a_fault_frozen: assert property (st_q.state == ext_state_pkg::S_DONE && // R25
		st_q.res.fault != ext_state_pkg::F_NONE |-> $stable(st_q.inUse) &&
		$stable(st_q.modified) && $stable(st_q.simd)) else $error("faulting op changed state");
	a_modified_set: assert property (st_q.state == ext_state_pkg::S_APPLY && !hdrFault // R15
		|=> st_q.modified == ~st_q.mask) else $error("modified bitmap wrong");
	a_inuse_set: assert property (st_q.state == ext_state_pkg::S_APPLY && !hdrFault // R14
		|=> ((st_q.mask & st_q.present & ~st_q.inUse) == 64'h0)) else $error("in-use not set");
	a_simd_init: assert property (st_q.state == ext_state_pkg::S_APPLY && !hdrFault && simdInitW // R10
		|=> st_q.simd == ext_state_pkg::SIMD_INIT) else $error("simd reset value wrong");
	a_std_simd: assert property (st_q.state == ext_state_pkg::S_APPLY && !compactForm && // R6
		!hdrFault && (st_q.mask[1] || st_q.mask[2]) |=> st_q.res.simdLoad &&
		st_q.simd == $past(st_q.simdMem)) else $error("standard simd load wrong");
	a_save_skip: assert property (st_q.res.done && !st_q.isRestore // R24
		|-> (st_q.res.storeMask & ~st_q.inUse) == 64'h0) else $error("idle component stored");
	a_save_write: assert property (st_q.state == ext_state_pkg::S_SAVERD && memRsp.ack // R17
		|=> memReq.we && memReq.wdata == (($past(memRsp.rdata) & ~st_q.mask) |
		(st_q.inUse & st_q.mask))) else $error("present write-back wrong");

	c_compact_ok: cover property (st_q.res.done && st_q.res.compacted &&
		st_q.res.fault == ext_state_pkg::F_NONE);
	c_std_ok: cover property (st_q.res.done && st_q.isRestore && !st_q.res.compacted &&
		st_q.res.fault == ext_state_pkg::F_NONE);
	c_save_ok: cover property (st_q.res.done && !st_q.isRestore);
	c_prot_fault: cover property (st_q.res.done && st_q.res.fault == ext_state_pkg::F_PROT);

endmodule : ext_state_restore_save_ctl

/* File: verification/save_area_mem.sv */
// Behavioural memory that holds the state save area seen by the control block.
`timescale 1ns/1ps
module save_area_mem (
	input  wire logic                       clock,
	input  wire ext_state_pkg::mem_req_type memReq,
	output      ext_state_pkg::mem_rsp_type memRsp
);
	logic [63:0] store [logic [63:0]];
	int          delay   = 0;
	int          waitCnt = 0;

	// ------------------------------------------------------------
	// Access engine
	// ------------------------------------------------------------
	initial memRsp = '0;

	// Outside an ack the data bus toggles, so stale read data never looks valid.
	always @(posedge clock) begin
		if (memReq.req && memRsp.ack) begin
			if (memReq.we)
				store[memReq.addr] = memReq.wdata;
			memRsp.ack   <= 1'b0;
			memRsp.rdata <= ~memRsp.rdata;
			waitCnt = 0;
		end else if (memReq.req && waitCnt >= delay) begin
			memRsp.ack   <= 1'b1;
			memRsp.rdata <= store.exists(memReq.addr) ? store[memReq.addr] : 64'h0;
		end else begin
			memRsp.ack   <= 1'b0;
			memRsp.rdata <= ~memRsp.rdata;
			if (memReq.req)
				waitCnt++;
		end
	end
endmodule : save_area_mem

/* File: verification/tb.sv */
// Self-checking bench for the extended-state restore and save control block.
`timescale 1ns/1ps
module tb;
	localparam logic [63:0] CMP = 64'h8000_0000_0000_0000;

	logic                         clock;
	logic                         rst_b;
	ext_state_pkg::apb_req_type   apbReq;
	ext_state_pkg::apb_rsp_type   apbRsp;
	ext_state_pkg::instr_req_type instrReq;
	logic                         instrReady;
	ext_state_pkg::mem_req_type   memReq;
	ext_state_pkg::mem_rsp_type   memRsp;
	ext_state_pkg::result_type    result;
	ext_state_pkg::result_type    res;
	logic [31:0]                  simdCtlStatus;
	logic [47:0]                  x87InitWords;
	logic [31:0]                  rdv;
	logic                         err;
	int                           fails      = 0;
	int                           n_compared = 0;
	int                           cycles     = 0;
	logic [63:0]                  tPres [8];
	logic [63:0]                  tLay  [8];
	logic [63:0]                  tQ2   [8];
	logic [31:0]                  tSimd [8];

	ext_state_restore_save_ctl dut (
		.clock        (clock),
		.rst_b        (rst_b),
		.apbReq       (apbReq),
		.apbRsp       (apbRsp),
		.instrReq     (instrReq),
		.instrReady   (instrReady),
		.memReq       (memReq),
		.memRsp       (memRsp),
		.result       (result),
		.simdCtlStatus(simdCtlStatus),
		.x87InitWords (x87InitWords)
	);

	save_area_mem mem (
		.clock (clock),
		.memReq(memReq),
		.memRsp(memRsp)
	);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// A hung handshake ends the run here instead of waiting forever.
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			tally_and_finish();
		end
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic tally_and_finish();
		$display("compared %0d mismatched %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// The request is released one edge before the task returns, so no signal is driven twice.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic er);
		apbReq <= '{1'b1, 1'b0, wr, a, wd};
		@(posedge clock);
		apbReq.penable <= 1'b1;
		do @(posedge clock); while (apbRsp.pready !== 1'b1);
		rd = apbRsp.prdata;
		er = apbRsp.pslverr;
		apbReq <= '0;
		@(posedge clock);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rdv, err);
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0, rdv, err);
		chk(nm, {32'h0, e}, {32'h0, rdv});
	endtask : rdchk

	task automatic run(input logic rs, input logic [63:0] msk, input logic [63:0] ar);
		int n;
		n = 0;
		instrReq <= '{1'b1, rs, msk, ar, 2'h3, 1'b0};
		do @(posedge clock); while (instrReady !== 1'b1);
		instrReq.valid <= 1'b0;
		do begin
			@(posedge clock);
			n++;
		end while (result.done !== 1'b1 && n < 500);
		if (n >= 500)
			fails++;
		res = result;
	endtask : run

	task automatic rst_run(input logic [63:0] ar, input logic [63:0] msk, input logic [63:0] pr,
			input logic [63:0] ly, input logic [63:0] q2, input logic [31:0] sm);
		mem.store[ar + 64'h200] = pr;
		mem.store[ar + 64'h208] = ly;
		mem.store[ar + 64'h210] = q2;
		mem.store[ar + 64'h18] = {32'h0, sm};
		run(1'b1, msk, ar);
	endtask : rst_run

	task automatic chk_res(input logic [1:0] f, input logic [63:0] ld, input logic [63:0] ini,
			input logic sl, input logic si);
		chk("fault", {62'h0, f}, {62'h0, res.fault});
		if (f != 2'h0)
			return;
		chk("loadMask", ld, res.loadMask);
		chk("initMask", ini, res.initMask);
		chk("simdLoad", {63'h0, sl}, {63'h0, res.simdLoad});
		chk("simdInit", {63'h0, si}, {63'h0, res.simdInit});
	endtask : chk_res

	task automatic flt(input logic [31:0] c, input logic [63:0] ar, input logic [1:0] f);
		wr(ext_state_pkg::OFS_CTRL, c);
		run(1'b1, '1, ar);
		chk_res(f, 64'h0, 64'h0, 1'b0, 1'b0);
		rdchk(ext_state_pkg::OFS_USE_LO, 32'h0, "inUseKept");
	endtask : flt

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		rst_b = 1'b0;
		apbReq = '0;
		instrReq = '0;
		tPres = '{64'h8, 64'h1, 64'h1, 64'h1, 64'h1, 64'h4, 64'h1, 64'h1};
		tLay = '{64'h0, 64'h1, 64'h0, 64'h0, CMP | 64'h8, CMP | 64'h1, CMP | 64'h1, CMP | 64'h1};
		tQ2 = '{64'h0, 64'h0, 64'h1, 64'h0, 64'h0, 64'h0, 64'h1, 64'h0};
		tSimd = '{32'h1f80, 32'h1f80, 32'h1f80, 32'h1_0000, 32'h1f80, 32'h1f80, 32'h1f80,
		          32'h1f80};
		repeat (10) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		rdchk(ext_state_pkg::OFS_USE_LO, 32'h0, "inUseLo");
		rdchk(ext_state_pkg::OFS_MOD_HI, 32'hffff_ffff, "modHi");
		rdchk(ext_state_pkg::OFS_SIMD, 32'h1f80, "simd");
		chk("x87Init", {16'h0, 48'h037f_0000_ffff}, {16'h0, x87InitWords});
		apb(1'b0, 8'h24, 32'h0, rdv, err);
		chk("unmapped", {31'h0, 1'b1, 32'h0}, {31'h0, err, rdv});
		wr(ext_state_pkg::OFS_FEAT_LO, 32'h7);
		wr(ext_state_pkg::OFS_FEAT_HI, 32'h0);
		rdchk(ext_state_pkg::OFS_FEAT_LO, 32'h7, "featLo");
		$display("test registers done");
		mem.store[64'h1200] = 64'h5;
		flt(32'h8, 64'h1000, ext_state_pkg::F_UNDEF);
		flt(32'h9, 64'h1000, ext_state_pkg::F_UNAVAIL);
		flt(32'h1, 64'h1020, ext_state_pkg::F_PROT);
		$display("test entry faults done");
		rst_run(64'h1000, '1, 64'h5, 64'h0, 64'h0, 32'h1fa0);
		chk_res(ext_state_pkg::F_NONE, 64'h5, 64'h2, 1'b1, 1'b0);
		chk("compacted", 64'h0, {63'h0, res.compacted});
		chk("simdPort", 64'h1fa0, {32'h0, simdCtlStatus});
		rdchk(ext_state_pkg::OFS_USE_LO, 32'h5, "inUseLo");
		rdchk(ext_state_pkg::OFS_MOD_LO, 32'hffff_fff8, "modLo");
		rdchk(ext_state_pkg::OFS_MOD_HI, 32'hffff_ffff, "modHi");
		$display("test standard restore done");
		mem.store[64'h1200] = 64'ha0;
		mem.store[64'h1218] = 64'h1234;
		run(1'b0, '1, 64'h1000);
		chk("storeMask", 64'h0, res.storeMask);
		chk("present", 64'ha5, mem.store[64'h1200]);
		chk("layout", 64'h0, mem.store[64'h1208]);
		chk("hdrRest", 64'h1234, mem.store[64'h1218]);
		run(1'b0, '1, 64'h2000);
		chk("storeMask", 64'h5, res.storeMask);
		chk("present", 64'h5, mem.store[64'h2200]);
		$display("test save done");
		mem.delay = 3;
		// The last case is clean except for a nonzero reserved word in bytes 63:56.
		// The standard restore at the same area later must ignore that word.
		mem.store[64'ha238] = 64'h1;
		for (int i = 0; i < 8; i++) begin
			rst_run(64'h3000 + 64'h1000 * i, '1, tPres[i], tLay[i], tQ2[i], tSimd[i]);
			chk_res(ext_state_pkg::F_PROT, 64'h0, 64'h0, 1'b0, 1'b0);
		end
		rdchk(ext_state_pkg::OFS_STATUS, 32'h0000_0003, "status");
		rdchk(ext_state_pkg::OFS_USE_LO, 32'h5, "inUseKept");
		rdchk(ext_state_pkg::OFS_SIMD, 32'h1fa0, "simdKept");
		$display("test header faults done");
		rst_run(64'ha000, 64'h4, 64'h0, 64'h0, 64'h0, 32'h1f00);
		chk_res(ext_state_pkg::F_NONE, 64'h0, 64'h4, 1'b1, 1'b0);
		chk("simdPort", 64'h1f00, {32'h0, simdCtlStatus});
		rdchk(ext_state_pkg::OFS_USE_LO, 32'h1, "inUseLo");
		rdchk(ext_state_pkg::OFS_MOD_LO, 32'hffff_fffb, "modLo");
		mem.delay = 0;
		rst_run(64'hb000, 64'h4, 64'h0, CMP | 64'h4, 64'h0, 32'h1fa0);
		chk_res(ext_state_pkg::F_NONE, 64'h0, 64'h4, 1'b0, 1'b0);
		chk("compacted", 64'h1, {63'h0, res.compacted});
		chk("simdPort", 64'h1f00, {32'h0, simdCtlStatus});
		rst_run(64'hc000, '1, 64'h1, CMP | 64'h1, 64'h0, 32'h1fa0);
		chk_res(ext_state_pkg::F_NONE, 64'h1, 64'h6, 1'b0, 1'b1);
		chk("simdPort", 64'h1f80, {32'h0, simdCtlStatus});
		run(1'b0, '1, 64'hc000);
		chk("storeMask", 64'h1, res.storeMask);
		$display("test compacted restore done");
		tally_and_finish();
	end
endmodule : tb
